/* include/sram_cfg.svh */
// How it works
// (RL1) store select high at edge means read
// (RL2) parity result one clock after data valid
// (RL3) port outputs change only on clock high
// (RL4) deselected cycle releases outputs after edge
// (RL5) drive pin high floats port at once
// (RL6) drive pin low turns port on at once
// (RL7) controller keeps enables stable for parity
// (RL8) no read drive soon after a write
// (RL9) address on fall, strobes on rise
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH

// register byte offsets
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_MASK 4'h8
`define OFS_INFO 4'hC

// control fields and reset value
`define CTRL_PAR_EN_BIT 0
`define CTRL_RESET 1'h1

// status and mask fields
`define EV_PARITY_BIT 0
`define EV_WRITE_BIT 1
`define EV_DESEL_BIT 2
`define EV_COUNT 3
`define MASK_RESET 3'h0

// info fields
`define INFO_ADDR_LSB 0
`define INFO_HOLD_BIT 16
`define INFO_DRIVE_BIT 17

// write-to-read recovery: least time rounds up to whole cycles
`define CLK_PERIOD_PS 5000
`define WR_RECOVER_NS 8
`define WR_RECOVER_CYC ((`WR_RECOVER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* include/sram_pkg.sv */
package sram_pkg;
  typedef logic [8:0] word_t;
  typedef logic [14:0] addr_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [1:0] hold_t;
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } cyc_t;
endpackage : sram_pkg

/* include/port_if.sv */
`timescale 1ns/1ps
interface port_if;
  import sram_pkg::*;
  word_t rd_word;
  logic load;
  logic allow;
  word_t din;
  modport core (output rd_word, output load, output allow, input din);
  modport pin (input rd_word, input load, input allow, output din);
endinterface : port_if

/* hdl/data_port.sv */
`timescale 1ns/1ps
module data_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic drive_n,
  input wire sram_pkg::word_t pin_in,
  output sram_pkg::word_t pin_out,
  output sram_pkg::word_t pin_oe,
  port_if.pin p
);
  import sram_pkg::*;

  word_t q_q;
  logic on_w;

  // output latch: loads only at the rising edge, so it holds while the clock is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 9'h000;
    end else if (ce && p.load) begin
      q_q <= p.rd_word; // RL3
    end
  end

  // enable is combinational from the pin so it acts without waiting for a clock
  assign on_w = !drive_n && p.allow; // RL5 RL6
  assign pin_oe = {9{on_w}};
  assign pin_out = q_q;
  assign p.din = pin_in;
endmodule : data_port

/* hdl/parity_check.sv */
`timescale 1ns/1ps
module parity_check (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic valid,
  input wire sram_pkg::word_t data,
  output logic fault,
  output logic fault_evt
);
  import sram_pkg::*;

  logic bad_w;
  logic fault_q;

  // odd parity: an even count of ones over all nine bits is an error
  assign bad_w = enable && valid && !(^data);

  // result sampled one edge after the data became valid; cleared otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      fault_q <= bad_w; // RL2
    end
  end

  assign fault = fault_q;
  assign fault_evt = bad_w && ce;
endmodule : parity_check

/* hdl/sram_top.sv */
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "sram_cfg.svh"
module sram_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire sram_pkg::addr_t MEM_ADDR,
  input wire logic SELECT_LOW_ACTIVE,
  input wire logic SELECT_HIGH_ACTIVE,
  input wire logic STORE_SELECT_N,
  input wire logic CPU_PORT_CAPTURE_N,
  input wire logic SYS_PORT_CAPTURE_N,
  input wire logic CPU_PORT_DRIVE_N,
  input wire logic SYS_PORT_DRIVE_N,
  input wire sram_pkg::word_t CPU_DQ_IN,
  output sram_pkg::word_t CPU_DQ_OUT,
  output sram_pkg::word_t CPU_DQ_OE,
  input wire sram_pkg::word_t SYS_DQ_IN,
  output sram_pkg::word_t SYS_DQ_OUT,
  output sram_pkg::word_t SYS_DQ_OE,
  output logic PARITY_FAULT_N_OUT,
  output logic PARITY_FAULT_N_OE,
  input wire sram_pkg::reg_addr_t REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ
);
  import sram_pkg::*;

  localparam int DEPTH = 32768;
  localparam hold_t HOLD_LOAD = hold_t'(`WR_RECOVER_CYC + 1);

  // storage array, no reset: contents are undefined until written
  word_t mem [DEPTH];

  // falling-edge samples of address and selects
  addr_t addr_q;
  logic sel_q;

  // rising-edge cycle state
  cyc_t cyc_q;
  cyc_t cyc_d;
  word_t rd_q;
  logic drive_q;
  logic drive_d;
  hold_t hold_q;
  hold_t hold_d;
  addr_t last_addr_q;

  // register file
  logic ctrl_par_en_q;
  logic [`EV_COUNT-1:0] status_q;
  logic [`EV_COUNT-1:0] status_d;
  logic [`EV_COUNT-1:0] mask_q;
  logic [31:0] rdata_q;

  port_if cpu_if ();
  port_if sys_if ();

  // decoded cycle kind at the rising edge
  logic any_cap_w;
  logic read_w;
  logic write_w;
  logic desel_w;
  word_t wr_word_w;

  assign any_cap_w = !CPU_PORT_CAPTURE_N || !SYS_PORT_CAPTURE_N;
  assign read_w = sel_q && STORE_SELECT_N; // RL1
  assign write_w = sel_q && !STORE_SELECT_N && any_cap_w;
  assign desel_w = !sel_q;
  // the processor port wins when both capture enables are low
  assign wr_word_w = !CPU_PORT_CAPTURE_N ? cpu_if.din : sys_if.din;

  // address and selects taken on the falling edge, half a cycle before use
  always_ff @(negedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_q <= 15'h0000;
      sel_q <= 1'b0;
    end else if (CE) begin
      addr_q <= MEM_ADDR; // RL9
      sel_q <= !SELECT_LOW_ACTIVE && SELECT_HIGH_ACTIVE; // RL9
    end
  end

  // array write; a read cycle never reaches this port
  always_ff @(posedge CLK) begin
    if (CE && write_w) begin
      mem[addr_q] <= wr_word_w; // RL1
    end
  end

  // next cycle state
  always_comb begin
    cyc_d = CYC_IDLE;
    if (write_w) begin
      cyc_d = CYC_WRITE;
    end else if (read_w) begin
      cyc_d = CYC_READ;
    end
  end

  // drive and write-recovery decisions per cycle kind
  always_comb begin
    drive_d = drive_q;
    hold_d = (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
    unique case (cyc_d)
      CYC_IDLE: begin
        drive_d = 1'b0; // RL4
      end
      CYC_READ: begin
        drive_d = 1'b1;
      end
      CYC_WRITE: begin
        // outputs float during a write and stay off through the recovery gap
        drive_d = 1'b0;
        hold_d = HOLD_LOAD; // RL8
      end
    endcase
  end

  // rising-edge state: cycle kind, drive, recovery count and last read address land here
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cyc_q <= CYC_IDLE;
      drive_q <= 1'b0;
      hold_q <= 2'h0;
      last_addr_q <= 15'h0000;
    end else if (CE) begin
      cyc_q <= cyc_d;
      drive_q <= drive_d; // RL4
      hold_q <= hold_d; // RL8
      if (read_w) begin
        last_addr_q <= addr_q;
      end
    end
  end

  // array read is a plain register so it maps onto block memory
  always_ff @(posedge CLK) begin
    if (CE && read_w) begin
      rd_q <= mem[addr_q];
    end
  end

  // both ports present the same word; each latch loads at the read edge
  assign cpu_if.rd_word = mem[addr_q];
  assign sys_if.rd_word = mem[addr_q];
  assign cpu_if.load = read_w; // RL3
  assign sys_if.load = read_w; // RL3
  // drivers on only after a selected read and outside write recovery
  assign cpu_if.allow = drive_q && (hold_q == 2'h0); // RL8
  assign sys_if.allow = drive_q && (hold_q == 2'h0); // RL8

  data_port u_cpu (
    .clk(CLK),
    .rst_n(RESETN),
    .ce(CE),
    .drive_n(CPU_PORT_DRIVE_N),
    .pin_in(CPU_DQ_IN),
    .pin_out(CPU_DQ_OUT),
    .pin_oe(CPU_DQ_OE),
    .p(cpu_if.pin)
  );

  data_port u_sys (
    .clk(CLK),
    .rst_n(RESETN),
    .ce(CE),
    .drive_n(SYS_PORT_DRIVE_N),
    .pin_in(SYS_DQ_IN),
    .pin_out(SYS_DQ_OUT),
    .pin_oe(SYS_DQ_OE),
    .p(sys_if.pin)
  );

  // parity result trails the data by one edge; the check relies on stable
  // capture and drive enables around the edge, which the controller provides
  logic fault_w;
  logic fault_evt_w;
  logic rd_valid_w;

  assign rd_valid_w = (cyc_q == CYC_READ); // RL7

  parity_check u_par (
    .clk(CLK),
    .rst_n(RESETN),
    .ce(CE),
    .enable(ctrl_par_en_q),
    .valid(rd_valid_w),
    .data(rd_q),
    .fault(fault_w),
    .fault_evt(fault_evt_w)
  );

  // open drain: only ever pulls low
  assign PARITY_FAULT_N_OUT = 1'b0;
  assign PARITY_FAULT_N_OE = fault_w; // RL2

  // register bus decode
  logic hit_ctrl_w;
  logic hit_status_w;
  logic hit_mask_w;
  logic hit_info_w;
  logic [`EV_COUNT-1:0] ev_w;
  logic [`EV_COUNT-1:0] w1c_w;
  logic [31:0] info_w;
  logic [31:0] rsel_w;

  assign hit_ctrl_w = (REG_ADDR == `OFS_CTRL);
  assign hit_status_w = (REG_ADDR == `OFS_STATUS);
  assign hit_mask_w = (REG_ADDR == `OFS_MASK);
  assign hit_info_w = (REG_ADDR == `OFS_INFO);

  // events: parity error, array write, deselected cycle while drive_q is set
  assign ev_w[`EV_PARITY_BIT] = fault_evt_w;
  assign ev_w[`EV_WRITE_BIT] = CE && write_w;
  assign ev_w[`EV_DESEL_BIT] = CE && desel_w && drive_q;

  assign w1c_w = (REG_WR && hit_status_w) ? REG_WDATA[`EV_COUNT-1:0] : 3'h0;
  // an event in the same cycle as its clear keeps the bit set
  assign status_d = (status_q & ~w1c_w) | ev_w;

  always_comb begin
    info_w = 32'h0000_0000;
    info_w[`INFO_ADDR_LSB +: 15] = last_addr_q;
    info_w[`INFO_HOLD_BIT] = (hold_q != 2'h0);
    info_w[`INFO_DRIVE_BIT] = drive_q;
  end

  // unmapped offsets read as zero
  assign rsel_w = hit_ctrl_w ? {31'h0000_0000, ctrl_par_en_q} :
                  hit_status_w ? {29'h0000_0000, status_q} :
                  hit_mask_w ? {29'h0000_0000, mask_q} :
                  hit_info_w ? info_w : 32'h0000_0000;

  // control and mask writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_par_en_q <= `CTRL_RESET;
      mask_q <= `MASK_RESET;
    end else if (CE && REG_WR) begin
      if (hit_ctrl_w) begin
        ctrl_par_en_q <= REG_WDATA[`CTRL_PAR_EN_BIT];
      end
      if (hit_mask_w) begin
        mask_q <= REG_WDATA[`EV_COUNT-1:0];
      end
    end
  end

  // sticky status
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_q <= 3'h0;
    end else if (CE) begin
      status_q <= status_d;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      rdata_q <= REG_RD ? rsel_w : 32'h0000_0000;
    end
  end

  assign REG_RDATA = rdata_q;
  assign IRQ = |(status_q & mask_q);
endmodule : sram_top

/* bench/sram_top_properties.sv */
`timescale 1ns/1ps
module sram_top_properties (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic SELECT_LOW_ACTIVE,
  input wire logic SELECT_HIGH_ACTIVE,
  input wire logic STORE_SELECT_N,
  input wire logic CPU_PORT_CAPTURE_N,
  input wire logic SYS_PORT_CAPTURE_N,
  input wire logic CPU_PORT_DRIVE_N,
  input wire logic SYS_PORT_DRIVE_N,
  input wire sram_pkg::word_t CPU_DQ_OUT,
  input wire sram_pkg::word_t CPU_DQ_OE,
  input wire sram_pkg::word_t SYS_DQ_OE,
  input wire logic PARITY_FAULT_N_OUT,
  input wire logic PARITY_FAULT_N_OE
);
  import sram_pkg::*;
  logic sel_q;
  word_t low_q;
  logic [2:0] wr_q;
  wire rd = CE & sel_q & STORE_SELECT_N;
  wire wr = CE & sel_q & ~STORE_SELECT_N & ~(CPU_PORT_CAPTURE_N & SYS_PORT_CAPTURE_N);
  // selects are taken on the falling edge; the data seen there must survive the low phase
  always_ff @(negedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_q <= 1'b0;
      low_q <= 9'h000;
    end else begin
      if (CE) sel_q <= !SELECT_LOW_ACTIVE & SELECT_HIGH_ACTIVE;
      low_q <= CPU_DQ_OUT;
    end
  end
  // recent writes, so a read inside the recovery time is not expected to drive
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) wr_q <= 3'h0;
    else wr_q <= {wr_q[1:0], wr};
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  AST_CPU_FLOAT: assert property (CPU_PORT_DRIVE_N |-> CPU_DQ_OE == 9'h000) else $error("cpu oe");
  AST_SYS_FLOAT: assert property (SYS_PORT_DRIVE_N |-> SYS_DQ_OE == 9'h000) else $error("sys oe");
  AST_CPU_ON: assert property (rd && wr_q == 3'h0 ##1 !CPU_PORT_DRIVE_N |-> CPU_DQ_OE == 9'h1FF)
    else $error("cpu not driven");
  AST_DESEL: assert property (CE && !sel_q |=> CPU_DQ_OE == 9'h000 && SYS_DQ_OE == 9'h000)
    else $error("deselect drives");
  AST_RECOVER: assert property (wr |=> (CPU_DQ_OE == 9'h000) [*3]) else $error("early drive");
  AST_PAR_TIME: assert property (PARITY_FAULT_N_OE |-> $past(rd, 2) && ~^$past(CPU_DQ_OUT))
    else $error("parity fault");
  AST_LATCH: assert property (CPU_DQ_OUT == low_q) else $error("data moved in low phase");
  AST_OD_LOW: assert property (PARITY_FAULT_N_OUT == 1'b0) else $error("fault pin level");
endmodule : sram_top_properties

bind sram_top sram_top_properties sram_top_properties_i (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .SELECT_LOW_ACTIVE(SELECT_LOW_ACTIVE), .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE),
  .STORE_SELECT_N(STORE_SELECT_N), .CPU_PORT_CAPTURE_N(CPU_PORT_CAPTURE_N),
  .SYS_PORT_CAPTURE_N(SYS_PORT_CAPTURE_N), .CPU_PORT_DRIVE_N(CPU_PORT_DRIVE_N),
  .SYS_PORT_DRIVE_N(SYS_PORT_DRIVE_N), .CPU_DQ_OUT(CPU_DQ_OUT), .CPU_DQ_OE(CPU_DQ_OE),
  .SYS_DQ_OE(SYS_DQ_OE), .PARITY_FAULT_N_OUT(PARITY_FAULT_N_OUT), .PARITY_FAULT_N_OE(PARITY_FAULT_N_OE));

/* bench/mem_ctl.sv */
`timescale 1ns/1ps
module mem_ctl (
  input wire logic clk,
  output sram_pkg::addr_t addr,
  output logic sel_low_n,
  output logic sel_high,
  output logic store_n,
  output logic cap_cpu_n,
  output logic cap_sys_n,
  output logic drv_cpu_n,
  output logic drv_sys_n,
  output sram_pkg::word_t cpu_din,
  output sram_pkg::word_t sys_din
);
  import sram_pkg::*;
  // start deselected with both ports floating
  initial begin
    addr = 15'h0000;
    sel_low_n = 1'b1;
    sel_high = 1'b0;
    store_n = 1'b1;
    cap_cpu_n = 1'b1;
    cap_sys_n = 1'b1;
    drv_cpu_n = 1'b1;
    drv_sys_n = 1'b1;
    cpu_din = 9'h000;
    sys_din = 9'h000;
  end
  // kind 0 read, 1 cpu write, 2 sys write, 3 deselect, 4 idle; launched after a rising edge
  task automatic op(input int k, input addr_t a, input word_t d, input logic [1:0] drv);
    @(posedge clk);
    addr <= a;
    sel_low_n <= k == 3 && d[0];
    sel_high <= !(k == 3 && !d[0]);
    store_n <= k == 0 || k == 3;
    cap_cpu_n <= k != 1;
    cap_sys_n <= k != 2;
    drv_cpu_n <= drv[0];
    drv_sys_n <= drv[1];
    // an undriven data line shows the inverse, so stale data never passes for fresh
    cpu_din <= k == 1 ? d : ~cpu_din;
    sys_din <= k == 2 ? d : ~sys_din;
  endtask : op
endmodule : mem_ctl

/* bench/sync_sram_read_parity_path_tb_top.sv */
`timescale 1ns/1ps
module sync_sram_read_parity_path_tb_top;
  import sram_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sl, sh, st, cc, cs, dc, ds, pfo, pf, irq;
  addr_t a;
  word_t ci, si, co, coe, so, sys_port_drive_n, exp_dq;
  reg_addr_t ra = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdata;
  int fail_count = 0, tests_run = 0, rec = 0;
  int unsigned seed = 10722;
  word_t mem[int];
  logic sel, drv, par, pend, pen;
  always #2.5 clk = ~clk;
  mem_ctl mem_ctl_i (.clk(clk), .addr(a), .sel_low_n(sl), .sel_high(sh), .store_n(st), .cap_cpu_n(cc),
    .cap_sys_n(cs), .drv_cpu_n(dc), .drv_sys_n(ds), .cpu_din(ci), .sys_din(si));
  sram_top sram_top_i (.CLK(clk), .RESETN(rst_n), .CE(1'b1), .MEM_ADDR(a), .SELECT_LOW_ACTIVE(sl),
    .SELECT_HIGH_ACTIVE(sh), .STORE_SELECT_N(st), .CPU_PORT_CAPTURE_N(cc), .SYS_PORT_CAPTURE_N(cs),
    .CPU_PORT_DRIVE_N(dc), .SYS_PORT_DRIVE_N(ds), .CPU_DQ_IN(ci), .CPU_DQ_OUT(co), .CPU_DQ_OE(coe),
    .SYS_DQ_IN(si), .SYS_DQ_OUT(so), .SYS_DQ_OE(sys_port_drive_n), .PARITY_FAULT_N_OUT(pfo), .PARITY_FAULT_N_OE(pf),
    .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reg_write(input reg_addr_t ad, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ra <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input reg_addr_t ad, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    ra <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e, "register");
  endtask : reg_check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // model mirror of the falling-edge select capture
  always @(negedge clk) sel = rst_n && !sl && sh;
  // model of one rising edge; every result is compared once the edge has settled
  always @(posedge clk) begin
    if (!rst_n) begin
      {drv, par, pend} = 3'h0;
      pen = 1'b1;
      rec = 0;
      exp_dq = 9'h000;
    end else begin
      par = pend;
      pend = sel && st && pen && !(^mem[a]);
      if (sel && st) exp_dq = mem[a];
      if (rec > 0) rec--;
      if (sel && !st && !(cc && cs)) begin
        mem[a] = !cc ? ci : si;
        rec = 3;
      end
      drv = sel && st;
      #1;
      // a reset raised at this very edge has already cleared the design, so skip the look
      if (rst_n) begin
        chk(co, exp_dq, "cpu data");
        chk(so, exp_dq, "sys data");
        chk(coe, {9{drv && rec == 0 && !dc}}, "cpu enable");
        chk(sys_port_drive_n, {9{drv && rec == 0 && !ds}}, "sys enable");
        chk(pf, par, "parity");
      end
    end
  end
  // a hang counts against the run
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    int unsigned r;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reg_check(4'h0, 32'h0000_0001);
    reg_check(4'h8, 32'h0000_0000);
    for (int i = 0; i < 8; i++) mem_ctl_i.op(1 + i % 2, addr_t'(i), word_t'(rnd()), 2'h0);
    mem_ctl_i.op(2, 15'h7FFF, 9'h0FF, 2'h0);
    repeat (4) mem_ctl_i.op(0, 15'h7FFF, 9'h000, 2'h0);
    mem_ctl_i.op(4, 15'h0000, 9'h000, 2'h0);
    reg_write(4'h0, 32'h0000_0000);
    pen = 1'b0;
    repeat (2) mem_ctl_i.op(0, 15'h7FFF, 9'h000, 2'h0);
    mem_ctl_i.op(4, 15'h0000, 9'h000, 2'h0);
    reg_write(4'h0, 32'h0000_0001);
    pen = 1'b1;
    $display("recovery and parity test done");
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      mem_ctl_i.op(r % 5, {12'h000, r[7:5]}, word_t'(r >> 8), r[9:8]);
    end
    mem_ctl_i.op(0, 15'h7FFF, 9'h000, 2'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(coe, 9'h000, "reset enable");
    chk(pf, 1'b0, "reset parity");
    rst_n <= 1'b1;
    $display("random and reset test done");
    mem_ctl_i.op(4, 15'h0000, 9'h000, 2'h0);
    reg_write(4'h4, 32'h0000_0007);
    reg_check(4'h4, 32'h0000_0000);
    mem_ctl_i.op(1, 15'h0003, 9'h003, 2'h0);
    mem_ctl_i.op(0, 15'h0003, 9'h000, 2'h0);
    mem_ctl_i.op(4, 15'h0000, 9'h000, 2'h0);
    reg_check(4'h4, 32'h0000_0003);
    chk(irq, 1'b0, "irq masked");
    reg_write(4'h8, 32'h0000_0002);
    reg_check(4'h8, 32'h0000_0002);
    chk(irq, 1'b1, "irq raised");
    reg_write(4'h4, 32'h0000_0002);
    reg_check(4'h4, 32'h0000_0001);
    chk(irq, 1'b0, "irq cleared");
    reg_write(4'h2, 32'hFFFF_FFFF);
    reg_check(4'h2, 32'h0000_0000);
    reg_check(4'hC, 32'h0000_0003); // last read address 3, no recovery, drivers off
    $display("register test done");
    tally_and_finish();
  end
endmodule : sync_sram_read_parity_path_tb_top
